//--- logic/riu_addr_gen.sv
// Operand address former for the rotate instruction unit.
// Assumes bank select and index base are stable while an instruction issues.
`timescale 1ns/1ns
module riu_addr_gen
(
    input  wire logic [7:0]  fileReg,
    input  wire logic        accessSel,
    input  wire logic [3:0]  bankSelect,
    input  wire logic        extEnable,
    input  wire logic [11:0] indexBase,
    output logic      [11:0] operandAddr,
    output logic             indexedMode
);

    ////////////////////////////////////////////////////////////////////////
    // Address selection
    always_comb
    begin
        indexedMode = !accessSel && extEnable && (fileReg <= riu_pkg::ILO_LIMIT);
        if (indexedMode)
        begin
            operandAddr = 12'(indexBase + {4'h0, fileReg});
        end
        else if (accessSel)
        begin
            operandAddr = {bankSelect, fileReg};
        end
        else if (fileReg <= riu_pkg::ILO_LIMIT)
        begin
            operandAddr = {riu_pkg::ACCESS_LOW, fileReg};
        end
        else
        begin
            operandAddr = {riu_pkg::ACCESS_HIGH, fileReg};
        end
    end

endmodule

//--- logic/rotate_instruction_unit.sv
// Rotate instruction unit: decodes and executes the three rotate opcodes.
// Assumes the file memory answers a read in the same cycle as its address.
`timescale 1ns/1ns
module rotate_instruction_unit
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        instrValid,
    input  wire logic [15:0] instrWord,
    output logic             instrReady,
    input  wire logic [3:0]  bankSelect,
    input  wire logic        extEnable,
    input  wire logic [11:0] indexBase,
    output logic      [11:0] fileAddr,
    output logic             fileRdEn,
    input  wire logic [7:0]  fileRdData,
    output logic             fileWrEn,
    output logic      [7:0]  fileWrData,
    output logic      [7:0]  accumulator,
    output logic             carryFlag,
    output logic             negativeFlag,
    output logic             zeroFlag,
    output logic             indexedMode,
    output logic             done
);

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic riu_pkg::riu_op_e riu_decode(input logic [15:0] w);
        logic [5:0] opc;
        opc = w[riu_pkg::OPC_MSB:riu_pkg::OPC_LSB];
        case (opc)
            riu_pkg::OPC_RLNC: riu_decode = riu_pkg::RIU_OP_RLNC;
            riu_pkg::OPC_RRC:  riu_decode = riu_pkg::RIU_OP_RRC;
            riu_pkg::OPC_RLC:  riu_decode = riu_pkg::RIU_OP_RLC;
            default:           riu_decode = riu_pkg::RIU_OP_NONE;
        endcase
    endfunction

    // Returns {carry, result}
    function automatic logic [8:0] riu_rotate(input riu_pkg::riu_op_e op,
                                              input logic [7:0] d,
                                              input logic c);
        case (op)
            riu_pkg::RIU_OP_RLNC: riu_rotate = {c, d[6:0], d[7]};
            riu_pkg::RIU_OP_RRC:  riu_rotate = {d[0], c, d[7:1]};
            riu_pkg::RIU_OP_RLC:  riu_rotate = {d[7], d[6:0], c};
            default:              riu_rotate = {c, d};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    riu_pkg::riu_state_e state;
    riu_pkg::riu_state_e next_state;
    riu_pkg::riu_op_e    op;
    riu_pkg::riu_op_e    next_op;
    riu_pkg::riu_op_e    decOp;
    logic                dest;
    logic                next_dest;
    logic [11:0]         next_fileAddr;
    logic                next_fileRdEn;
    logic                next_fileWrEn;
    logic [7:0]          next_fileWrData;
    logic [7:0]          next_accumulator;
    logic                next_carryFlag;
    logic                next_negativeFlag;
    logic                next_zeroFlag;
    logic                next_indexedMode;
    logic                next_done;
    logic [8:0]          rot;
    logic [11:0]         genAddr;
    logic                genIndexed;

    riu_addr_gen u_addr
    (
        .fileReg     (instrWord[riu_pkg::FREG_MSB:0]),
        .accessSel   (instrWord[riu_pkg::ACCESS_BIT]),
        .bankSelect  (bankSelect),
        .extEnable   (extEnable),
        .indexBase   (indexBase),
        .operandAddr (genAddr),
        .indexedMode (genIndexed)
    );

    assign instrReady = (state == riu_pkg::RIU_ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        decOp             = riu_decode(instrWord);
        rot               = riu_rotate(op, fileRdData, carryFlag);
        next_state        = state;
        next_op           = op;
        next_dest         = dest;
        next_fileAddr     = fileAddr;
        next_fileRdEn     = 1'b0;
        next_fileWrEn     = 1'b0;
        next_fileWrData   = fileWrData;
        next_accumulator  = accumulator;
        next_carryFlag    = carryFlag;
        next_negativeFlag = negativeFlag;
        next_zeroFlag     = zeroFlag;
        next_indexedMode  = indexedMode;
        next_done         = 1'b0;
        case (state)
            riu_pkg::RIU_ST_IDLE:
            begin
                if (instrValid && decOp != riu_pkg::RIU_OP_NONE)
                begin
                    next_state       = riu_pkg::RIU_ST_READ;
                    next_op          = decOp;
                    next_dest        = instrWord[riu_pkg::DEST_BIT];
                    next_fileAddr    = genAddr;
                    next_indexedMode = genIndexed;
                    next_fileRdEn    = 1'b1;
                end
            end
            riu_pkg::RIU_ST_READ:
            begin
                next_fileWrData   = rot[7:0];
                next_carryFlag    = rot[8];
                next_negativeFlag = rot[7];
                next_zeroFlag     = (rot[7:0] == 8'h00);
                if (dest)
                begin
                    next_fileWrEn = 1'b1;
                end
                else
                begin
                    next_accumulator = rot[7:0];
                end
                next_done  = 1'b1;
                next_state = riu_pkg::RIU_ST_IDLE;
            end
            default:
            begin
                next_state = riu_pkg::RIU_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state        <= riu_pkg::RIU_ST_IDLE;
            op           <= riu_pkg::RIU_OP_NONE;
            dest         <= 1'b0;
            fileAddr     <= riu_pkg::ADDR_RST;
            fileRdEn     <= 1'b0;
            fileWrEn     <= 1'b0;
            fileWrData   <= riu_pkg::ACC_RST;
            accumulator  <= riu_pkg::ACC_RST;
            carryFlag    <= riu_pkg::FLAG_RST;
            negativeFlag <= riu_pkg::FLAG_RST;
            zeroFlag     <= riu_pkg::FLAG_RST;
            indexedMode  <= 1'b0;
            done         <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            op           <= next_op;
            dest         <= next_dest;
            fileAddr     <= next_fileAddr;
            fileRdEn     <= next_fileRdEn;
            fileWrEn     <= next_fileWrEn;
            fileWrData   <= next_fileWrData;
            accumulator  <= next_accumulator;
            carryFlag    <= next_carryFlag;
            negativeFlag <= next_negativeFlag;
            zeroFlag     <= next_zeroFlag;
            indexedMode  <= next_indexedMode;
            done         <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic inRead;
    logic accepted;
    assign inRead   = (state == riu_pkg::RIU_ST_READ);
    assign accepted = instrValid && instrReady
                      && (decOp != riu_pkg::RIU_OP_NONE);

    rlnc_result_a: assert property (
        inRead && op == riu_pkg::RIU_OP_RLNC |=> done
        && fileWrData == {$past(fileRdData[6:0]), $past(fileRdData[7])}
        && carryFlag == $past(carryFlag))
        else $error("rotate left no carry wrong");

    rrc_result_a: assert property (
        inRead && op == riu_pkg::RIU_OP_RRC |=>
        fileWrData == {$past(carryFlag), $past(fileRdData[7:1])}
        && carryFlag == $past(fileRdData[0]))
        else $error("rotate right carry wrong");

    rlc_result_a: assert property (
        inRead && op == riu_pkg::RIU_OP_RLC |=>
        fileWrData == {$past(fileRdData[6:0]), $past(carryFlag)}
        && carryFlag == $past(fileRdData[7]))
        else $error("rotate left carry wrong");

    decode_rrc_a: assert property (
        instrReady && instrValid && instrWord[15:10] == 6'h0C
        |=> op == riu_pkg::RIU_OP_RRC && fileRdEn ##1 done)
        else $error("right rotate decode wrong");

    decode_rlnc_a: assert property (
        instrReady && instrValid && instrWord[15:10] == 6'h11
        |=> op == riu_pkg::RIU_OP_RLNC ##1 done)
        else $error("left no carry decode wrong");

    dest_acc_a: assert property (
        accepted && !instrWord[9] |=> ##1 !fileWrEn
        && accumulator == fileWrData)
        else $error("accumulator target wrong");

    dest_file_a: assert property (
        accepted && instrWord[9] |=> ##1 fileWrEn
        && fileAddr == $past(fileAddr) && $stable(accumulator))
        else $error("write back wrong");

    bank_sel_a: assert property (
        accepted && instrWord[8] |=> !indexedMode
        && fileAddr == {$past(bankSelect), $past(instrWord[7:0])})
        else $error("bank address wrong");

    indexed_a: assert property (
        accepted && !instrWord[8] && extEnable && instrWord[7:0] <= 8'h5F
        |=> indexedMode
        && fileAddr == 12'($past(indexBase) + $past(instrWord[7:0])))
        else $error("indexed address wrong");

    flags_a: assert property (
        done |-> negativeFlag == fileWrData[7]
        && zeroFlag == (fileWrData == 8'h00))
        else $error("flags wrong");

    rrc_cov: cover property (accepted && decOp == riu_pkg::RIU_OP_RRC ##2 done);
    wb_cov:  cover property (accepted && instrWord[9] ##2 fileWrEn);
    ilo_cov: cover property (accepted && genIndexed ##2 done);
    b2b_cov: cover property (done && accepted);

endmodule

//--- shared/riu_pkg.sv
// Package for the rotate instruction unit: opcodes, fields, limits, types.
// Assumes 16-bit instruction words and a 12-bit data address space.
package riu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Instruction fields
    localparam int         OPC_MSB      = 15;
    localparam int         OPC_LSB      = 10;
    localparam int         DEST_BIT     = 9;
    localparam int         ACCESS_BIT   = 8;
    localparam int         FREG_MSB     = 7;
    localparam logic [5:0] OPC_RLNC     = 6'h11;
    localparam logic [5:0] OPC_RRC      = 6'h0C;
    localparam logic [5:0] OPC_RLC      = 6'h0D;

    ////////////////////////////////////////////////////////////////////////
    // Addressing
    localparam logic [7:0] ILO_LIMIT    = 8'h5F;
    localparam logic [3:0] ACCESS_LOW   = 4'h0;
    localparam logic [3:0] ACCESS_HIGH  = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  ACC_RST     = 8'h00;
    localparam logic [11:0] ADDR_RST    = 12'h000;
    localparam logic        FLAG_RST    = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        RIU_OP_NONE,
        RIU_OP_RLNC,
        RIU_OP_RRC,
        RIU_OP_RLC
    } riu_op_e;

    typedef enum logic {
        RIU_ST_IDLE,
        RIU_ST_READ
    } riu_state_e;

endpackage

//--- tb/tb_top.sv
// Testbench for the rotate instruction unit: directed and random rotates.
// Assumes read one cycle and done two cycles after an instruction is taken.
`timescale 1ns/1ns
module tb_top;
    logic        clk;
    logic        rst;
    logic        instrValid;
    logic [15:0] instrWord;
    logic        instrReady;
    logic [3:0]  bankSelect;
    logic        extEnable;
    logic [11:0] indexBase;
    logic [11:0] fileAddr;
    logic        fileRdEn;
    logic [7:0]  fileRdData;
    logic        fileWrEn;
    logic [7:0]  fileWrData;
    logic [7:0]  accumulator;
    logic        carryFlag;
    logic        negativeFlag;
    logic        zeroFlag;
    logic        indexedMode;
    logic        done;
    int          fail_count;
    int          checks;
    int          seed;
    logic        mC;
    logic [7:0]  mAcc;
    logic [31:0] k;
    logic [12:0] aExp;
    logic [12:0] addrQ[$];
    logic [19:0] resQ[$];
    logic [5:0]  ops[4];

    rotate_instruction_unit DUT
    (
        .clk(clk), .rst(rst), .instrValid(instrValid),
        .instrWord(instrWord), .instrReady(instrReady),
        .bankSelect(bankSelect), .extEnable(extEnable),
        .indexBase(indexBase), .fileAddr(fileAddr), .fileRdEn(fileRdEn),
        .fileRdData(fileRdData), .fileWrEn(fileWrEn),
        .fileWrData(fileWrData), .accumulator(accumulator),
        .carryFlag(carryFlag), .negativeFlag(negativeFlag),
        .zeroFlag(zeroFlag), .indexedMode(indexedMode), .done(done)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp,
                       input string what);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Drives one word and notes the expected address and result
    task automatic issue(input logic [5:0] op, input logic d, input logic a,
                         input logic [7:0] f, input logic [7:0] v);
        logic [7:0]  r;
        logic [11:0] ad;
        logic        ix;
        logic        ok;
        @(negedge clk);
        instrValid = 1'b1;
        instrWord = {op, d, a, f};
        fileRdData = v;
        ix = !a && extEnable && f <= 8'h5F;
        ad = ix ? indexBase + {4'h0, f} : a ? {bankSelect, f} :
             f <= 8'h5F ? {4'h0, f} : {4'hF, f};
        ok = 1'b1;
        r = 8'h00;
        case (op)
            riu_pkg::OPC_RLNC: r = {v[6:0], v[7]};
            riu_pkg::OPC_RRC:  {r, mC} = {mC, v};
            riu_pkg::OPC_RLC:  {mC, r} = {v, mC};
            default:           ok = 1'b0;
        endcase
        if (ok && !d)
            mAcc = r;
        if (ok)
        begin
            addrQ.push_back({ix, ad});
            resQ.push_back({r, d, mAcc, mC, r[7], r == 8'h00});
        end
        @(negedge clk);
        instrValid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #5000;
        fail_count++;
        end_sim();
    end

    // Takes the oldest note whenever the unit reads or completes
    always @(negedge clk)
    begin
        if (!rst && fileRdEn)
        begin
            if (addrQ.size() == 0)
                cmp(20'h1, 20'h0, "spurious read");
            else
            begin
                aExp = addrQ.pop_front();
                cmp({7'h00, indexedMode, fileAddr}, {7'h00, aExp}, "addr");
            end
        end
        if (!rst && done)
        begin
            if (resQ.size() == 0)
                cmp(20'h1, 20'h0, "spurious done");
            else
                cmp({fileWrData, fileWrEn, accumulator, carryFlag,
                     negativeFlag, zeroFlag}, resQ.pop_front(), "result");
        end
    end

    initial
    begin
        seed = 13;
        fail_count = 0;
        checks = 0;
        mC = 1'b0;
        mAcc = 8'h00;
        ops = '{riu_pkg::OPC_RLNC, riu_pkg::OPC_RRC, riu_pkg::OPC_RLC,
                riu_pkg::OPC_RRC};
        rst = 1'b1;
        instrValid = 1'b0;
        instrWord = 16'h0000;
        bankSelect = 4'h0;
        extEnable = 1'b0;
        indexBase = 12'h000;
        fileRdData = 8'h00;
        repeat (16) @(negedge clk);
        cmp({instrReady, fileRdEn, fileWrEn, done, indexedMode, carryFlag,
             negativeFlag, zeroFlag, fileAddr}, 20'h80000, "reset state");
        cmp({4'h0, fileWrData, accumulator}, 20'h00000, "reset data");
        rst = 1'b0;
        extEnable = 1'b1;
        indexBase = 12'hFF0;
        bankSelect = 4'h3;
        // Indexed boundary, wrap of the index sum
        issue(riu_pkg::OPC_RLNC, 1'b0, 1'b0, 8'h5F, 8'hAB);
        issue(riu_pkg::OPC_RRC, 1'b1, 1'b0, 8'h60, 8'h01);
        issue(riu_pkg::OPC_RLC, 1'b0, 1'b1, 8'h60, 8'h80);
        issue(6'h3F, 1'b0, 1'b0, 8'h10, 8'h55);
        issue(6'h10, 1'b1, 1'b0, 8'h10, 8'h55);
        extEnable = 1'b0;
        issue(riu_pkg::OPC_RLNC, 1'b1, 1'b0, 8'h10, 8'h00);
        issue(riu_pkg::OPC_RLNC, 1'b0, 1'b0, 8'h5F, 8'h7F);
        repeat (120)
        begin
            k = $random(seed);
            bankSelect = k[3:0];
            extEnable = k[4];
            indexBase = k[16:5];
            issue(ops[k[31:30]], k[29], k[28], k[27:20], 8'($random(seed)));
        end
        repeat (3) @(negedge clk);
        cmp(20'(addrQ.size() + resQ.size()), 20'h0, "missing answers");
        end_sim();
    end
endmodule
